// >>> rtl/dsf_pkg.sv
// Package: register map, field positions and reset values of the status and fault-summary block
package dsf_pkg;

    // ----------------------------------------------------------------
    // Bus geometry
    // ----------------------------------------------------------------
    localparam int          DSF_ADDR_W          = 12;
    localparam int          DSF_DATA_W          = 32;
    localparam logic [1:0]  DSF_RESP_OKAY       = 2'h0;
    localparam logic [1:0]  DSF_RESP_SLVERR     = 2'h2;

    // ----------------------------------------------------------------
    // Register indices (byte address is four times the index)
    // ----------------------------------------------------------------
    localparam logic [9:0]  DSF_IDX_STATUS      = 10'h051;
    localparam logic [9:0]  DSF_IDX_SUMMARY     = 10'h052;
    localparam logic [9:0]  DSF_IDX_CONFIG      = 10'h060;
    localparam logic [9:0]  DSF_IDX_IRQ_STATUS  = 10'h061;
    localparam logic [9:0]  DSF_IDX_IRQ_MASK    = 10'h062;

    // ----------------------------------------------------------------
    // device_status fields
    // ----------------------------------------------------------------
    localparam int          DSF_ST_INIT         = 0;
    localparam int          DSF_ST_SAMPLE       = 1;
    localparam int          DSF_ST_LINK_RESET   = 3;
    localparam int          DSF_ST_LINK_CLEAR   = 4;
    localparam int          DSF_ST_CHAIN_LATCH  = 5;
    localparam int          DSF_ST_CHAIN_LIVE   = 6;
    localparam int          DSF_ST_ANY_FAULT    = 7;

    // ----------------------------------------------------------------
    // fault_summary fields: type k sits at bit DSF_SUM_MSB - k
    // ----------------------------------------------------------------
    localparam int          DSF_FAULT_TYPES     = 10;
    localparam int          DSF_FAULT_W         = 16;
    localparam int          DSF_SUM_MSB         = 15;
    localparam int          DSF_SUM_LSB         = 6;

    // ----------------------------------------------------------------
    // Configuration fields and reset value
    // ----------------------------------------------------------------
    localparam int          DSF_CFG_AUTOCLEAR   = 0;
    localparam int          DSF_CFG_UPSTREAM_EN = 1;
    localparam logic [1:0]  DSF_CFG_RESET       = 2'h2;

    // ----------------------------------------------------------------
    // Interrupt fields and reset values
    // ----------------------------------------------------------------
    localparam int          DSF_IRQ_W           = 5;
    localparam int          DSF_IRQ_CHAIN       = 0;
    localparam int          DSF_IRQ_LINK_CLEAR  = 1;
    localparam int          DSF_IRQ_LINK_RESET  = 2;
    localparam int          DSF_IRQ_SAMPLE      = 3;
    localparam int          DSF_IRQ_FAULT       = 4;
    localparam logic [4:0]  DSF_IRQ_MASK_RESET  = 5'h00;

endpackage : dsf_pkg

// >>> rtl/dsf_status_regs.sv
// Device status, fault summary, individual fault store and AXI4-Lite register slave
//
// Summary of operation
// - any_fault_active reads one while any fault register bit is set; read only.
// - chain_fault_live follows the fault input pin; self-clearing; read only.
// - Live chain fault drives fault output; both chain bits masked when upstream disabled.
// - chain_fault_latched sets on a pin fault while upstream is enabled, holds until a one is written.
// - chain_fault_latched never reaches the fault output.
// - link_clear_seen sets on a clear event, write one clears, no fault output.
// - link_reset_seen sets on a reset event, write one clears, no fault output.
// - sample_available is status bit one, read only, set when results exist.
// - Any host read of result data clears sample_available.
// - Automatic temperature or initialization samples never set sample_available.
// - One sample_available flag covers every channel.
// - init_in_progress is status bit zero, one while initialization runs.
// - Writing one to init_in_progress ends the supply wait; zero does nothing.
// - Ten summary bits from bit 15 down to 6; bits 5 to 0 read zero.
// - A summary bit reads one while any fault of its type is set.
// - Writing one to a summary bit clears all faults of that type.
// - Summary bits derive directly from the fault store, latched or self-clearing.
// - fault_autoclear_mode makes fault bits follow their condition; else they latch.
//
// The AXI4-Lite slave port was decided locally.
`timescale 1ns/1ps
`default_nettype none

module dsf_status_regs
    import dsf_pkg::*;
(
    // Clock and reset
    input  wire logic                           clk,
    input  wire logic                           reset_n,
    // AXI4-Lite write address
    input  wire logic [dsf_pkg::DSF_ADDR_W-1:0] s_axi_awaddr,
    input  wire logic [2:0]                     s_axi_awprot,
    input  wire logic                           s_axi_awvalid,
    output var  logic                           s_axi_awready,
    // AXI4-Lite write data and response
    input  wire logic [dsf_pkg::DSF_DATA_W-1:0] s_axi_wdata,
    input  wire logic [3:0]                     s_axi_wstrb,
    input  wire logic                           s_axi_wvalid,
    output var  logic                           s_axi_wready,
    output var  logic [1:0]                     s_axi_bresp,
    output var  logic                           s_axi_bvalid,
    input  wire logic                           s_axi_bready,
    // AXI4-Lite read
    input  wire logic [dsf_pkg::DSF_ADDR_W-1:0] s_axi_araddr,
    input  wire logic [2:0]                     s_axi_arprot,
    input  wire logic                           s_axi_arvalid,
    output var  logic                           s_axi_arready,
    output var  logic [dsf_pkg::DSF_DATA_W-1:0] s_axi_rdata,
    output var  logic [1:0]                     s_axi_rresp,
    output var  logic                           s_axi_rvalid,
    input  wire logic                           s_axi_rready,
    // Chain fault pin and link events
    input  wire logic                           chain_fault_pin,
    input  wire logic                           link_clear_event,
    input  wire logic                           link_reset_event,
    // Sampling and initialization
    input  wire logic                           sample_collected,
    input  wire logic                           sample_auto,
    input  wire logic                           sample_read,
    input  wire logic                           init_busy,
    output logic                                init_skip_wait,
    // Raw fault conditions per type
    input  wire logic [dsf_pkg::DSF_FAULT_W-1:0] fault_raw [dsf_pkg::DSF_FAULT_TYPES],
    // Fault and interrupt outputs
    output logic                                fault_out,
    output logic                                irq
);
    import dsf_pkg::*;

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    function automatic logic [31:0] strb_mask(input logic [3:0] strb);
        strb_mask = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
    endfunction : strb_mask

    function automatic logic hit(input logic [9:0] idx);
        hit = (idx == DSF_IDX_STATUS) || (idx == DSF_IDX_SUMMARY) || (idx == DSF_IDX_CONFIG)
            || (idx == DSF_IDX_IRQ_STATUS) || (idx == DSF_IDX_IRQ_MASK);
    endfunction : hit

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    logic                   chain_meta;
    logic                   chain_sync;
    logic                   chain_live_q;
    logic                   any_fault_q;
    logic [1:0]             cfg;
    logic                   chain_latched;
    logic                   link_clear_seen;
    logic                   link_reset_seen;
    logic                   sample_available;
    logic [DSF_FAULT_W-1:0] fault_bits      [DSF_FAULT_TYPES];
    logic [DSF_FAULT_W-1:0] next_fault_bits [DSF_FAULT_TYPES];
    logic [DSF_IRQ_W-1:0]   irq_status;
    logic [DSF_IRQ_W-1:0]   irq_mask;
    logic                   aw_held;
    logic                   w_held;
    logic [9:0]             wr_idx;
    logic [31:0]            wr_data;
    logic [3:0]             wr_strb;

    // ----------------------------------------------------------------
    // Write decode
    // ----------------------------------------------------------------
    wire        wr_fire      = aw_held & w_held & ~s_axi_bvalid;
    wire [31:0] wr_ones      = wr_data & strb_mask(wr_strb);
    wire        wr_status    = wr_fire && (wr_idx == DSF_IDX_STATUS);
    wire        wr_summary   = wr_fire && (wr_idx == DSF_IDX_SUMMARY);
    wire        wr_config    = wr_fire && (wr_idx == DSF_IDX_CONFIG) && wr_strb[0];
    wire        wr_irq_stat  = wr_fire && (wr_idx == DSF_IDX_IRQ_STATUS);
    wire        wr_irq_mask  = wr_fire && (wr_idx == DSF_IDX_IRQ_MASK) && wr_strb[0];

    // ----------------------------------------------------------------
    // Derived status
    // ----------------------------------------------------------------
    wire        autoclear    = cfg[DSF_CFG_AUTOCLEAR];
    wire        upstream_en  = cfg[DSF_CFG_UPSTREAM_EN];
    wire        chain_live   = chain_sync & upstream_en;
    wire        latched_vis  = chain_latched & upstream_en;
    wire        sample_set   = sample_collected & ~sample_auto;
    wire        clr_latched  = wr_status & wr_ones[DSF_ST_CHAIN_LATCH];
    wire        clr_clear    = wr_status & wr_ones[DSF_ST_LINK_CLEAR];
    wire        clr_reset    = wr_status & wr_ones[DSF_ST_LINK_RESET];

    logic [DSF_FAULT_TYPES-1:0] type_active;
    logic [15:0]                summary_val;
    always_comb begin
        summary_val = 16'h0000;
        for (int k = 0; k < DSF_FAULT_TYPES; k++) begin
            type_active[k]                = |fault_bits[k];
            summary_val[DSF_SUM_MSB - k]  = type_active[k];
        end
    end

    wire        any_fault    = |type_active;
    wire [7:0]  status_val   = {any_fault, chain_live, latched_vis, link_clear_seen,
                                link_reset_seen, 1'b0, sample_available, init_busy};

    // ----------------------------------------------------------------
    // Individual fault store
    // ----------------------------------------------------------------
    always_comb begin
        for (int k = 0; k < DSF_FAULT_TYPES; k++) begin
            if (autoclear) begin
                next_fault_bits[k] = fault_raw[k];
            end else if (wr_summary && wr_ones[DSF_SUM_MSB - k]) begin
                next_fault_bits[k] = fault_raw[k];
            end else begin
                next_fault_bits[k] = fault_bits[k] | fault_raw[k];
            end
        end
    end

    always_ff @(posedge clk) begin
        for (int k = 0; k < DSF_FAULT_TYPES; k++) begin
            fault_bits[k] <= reset_n ? next_fault_bits[k] : '0;
        end
    end

    // ----------------------------------------------------------------
    // Chain pin synchroniser and status flags
    // ----------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            chain_meta       <= 1'b0;
            chain_sync       <= 1'b0;
            chain_latched    <= 1'b0;
            link_clear_seen  <= 1'b0;
            link_reset_seen  <= 1'b0;
            sample_available <= 1'b0;
        end else begin
            chain_meta       <= chain_fault_pin;
            chain_sync       <= chain_meta;
            chain_latched    <= chain_live | (chain_latched & ~clr_latched);
            link_clear_seen  <= link_clear_event | (link_clear_seen & ~clr_clear);
            link_reset_seen  <= link_reset_event | (link_reset_seen & ~clr_reset);
            sample_available <= sample_set | (sample_available & ~sample_read);
        end
    end

    // ----------------------------------------------------------------
    // Fault output, init skip, configuration, interrupts
    // ----------------------------------------------------------------
    wire [DSF_IRQ_W-1:0] irq_event = {any_fault & ~any_fault_q, sample_set, link_reset_event,
                                      link_clear_event, chain_live & ~chain_live_q};
    wire [DSF_IRQ_W-1:0] irq_clr   = wr_irq_stat ? wr_ones[DSF_IRQ_W-1:0] : '0;

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            fault_out      <= 1'b0;
            init_skip_wait <= 1'b0;
            chain_live_q   <= 1'b0;
            any_fault_q    <= 1'b0;
            cfg            <= DSF_CFG_RESET;
            irq_status     <= '0;
            irq_mask       <= DSF_IRQ_MASK_RESET;
            irq            <= 1'b0;
        end else begin
            fault_out      <= any_fault | chain_live;
            init_skip_wait <= wr_status & wr_ones[DSF_ST_INIT];
            chain_live_q   <= chain_live;
            any_fault_q    <= any_fault;
            if (wr_config) begin
                cfg <= wr_data[1:0];
            end
            irq_status     <= irq_event | (irq_status & ~irq_clr);
            if (wr_irq_mask) begin
                irq_mask <= wr_data[DSF_IRQ_W-1:0];
            end
            // A set mask bit keeps its status bit off the interrupt
            irq            <= |(irq_status & ~irq_mask);
        end
    end

    // ----------------------------------------------------------------
    // AXI4-Lite write channel
    // ----------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= DSF_RESP_OKAY;
            aw_held       <= 1'b0;
            w_held        <= 1'b0;
            wr_idx        <= '0;
            wr_data       <= '0;
            wr_strb       <= '0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held       <= 1'b1;
                wr_idx        <= s_axi_awaddr[11:2];
                s_axi_awready <= 1'b0;
            end else if (!aw_held && !s_axi_bvalid) begin
                s_axi_awready <= 1'b1;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held       <= 1'b1;
                wr_data      <= s_axi_wdata;
                wr_strb      <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end else if (!w_held && !s_axi_bvalid) begin
                s_axi_wready <= 1'b1;
            end
            if (wr_fire) begin
                aw_held      <= 1'b0;
                w_held       <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= hit(wr_idx) ? DSF_RESP_OKAY : DSF_RESP_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // AXI4-Lite read channel
    // ----------------------------------------------------------------
    wire [9:0]  rd_idx = s_axi_araddr[11:2];
    logic [31:0] rd_val;
    always_comb begin
        unique case (rd_idx)
            DSF_IDX_STATUS:     rd_val = {24'h000000, status_val};
            DSF_IDX_SUMMARY:    rd_val = {16'h0000, summary_val};
            DSF_IDX_CONFIG:     rd_val = {30'h00000000, cfg};
            DSF_IDX_IRQ_STATUS: rd_val = {27'h0000000, irq_status};
            DSF_IDX_IRQ_MASK:   rd_val = {27'h0000000, irq_mask};
            default:            rd_val = 32'h00000000;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= '0;
            s_axi_rresp   <= DSF_RESP_OKAY;
        end else begin
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid  <= 1'b1;
                s_axi_rdata   <= rd_val;
                s_axi_rresp   <= hit(rd_idx) ? DSF_RESP_OKAY : DSF_RESP_SLVERR;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid  <= 1'b0;
                s_axi_arready <= 1'b1;
            end else if (!s_axi_rvalid) begin
                s_axi_arready <= 1'b1;
            end
        end
    end

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    property p_any_fault_out;
        (any_fault && !$past(any_fault)) |=> fault_out;
    endproperty
    a_any_fault_out: assert property (p_any_fault_out) else $error("fault output missed a fault");

    property p_live_follows;
        chain_sync && upstream_en |-> status_val[DSF_ST_CHAIN_LIVE] ##1 fault_out;
    endproperty
    a_live_follows: assert property (p_live_follows) else $error("chain live not reported");

    property p_mask_chain;
        !upstream_en |-> !status_val[DSF_ST_CHAIN_LIVE] && !status_val[DSF_ST_CHAIN_LATCH];
    endproperty
    a_mask_chain: assert property (p_mask_chain) else $error("chain bits not masked");

    property p_latched_hold;
        chain_latched && !clr_latched |=> chain_latched;
    endproperty
    a_latched_hold: assert property (p_latched_hold) else $error("chain latch lost");

    property p_latched_no_out;
        chain_latched && !chain_live && !any_fault |=> !fault_out;
    endproperty
    a_latched_no_out: assert property (p_latched_no_out) else $error("latched chain bit drove output");

    property p_clear_seen;
        link_clear_event |=> link_clear_seen ##1 (link_clear_seen || $past(clr_clear));
    endproperty
    a_clear_seen: assert property (p_clear_seen) else $error("link clear not recorded");

    property p_reset_seen;
        link_reset_seen && !clr_reset |=> link_reset_seen;
    endproperty
    a_reset_seen: assert property (p_reset_seen) else $error("link reset flag dropped");

    property p_sample_clear;
        sample_read && !sample_set |=> !sample_available;
    endproperty
    a_sample_clear: assert property (p_sample_clear) else $error("sample flag not cleared by read");

    property p_sample_ro;
        !sample_set && !sample_available |=> !sample_available;
    endproperty
    a_sample_ro: assert property (p_sample_ro) else $error("sample flag set without a sample");

    property p_sample_auto;
        sample_collected && sample_auto && !sample_available |=> !sample_available;
    endproperty
    a_sample_auto: assert property (p_sample_auto) else $error("automatic sample set flag");

    property p_init_skip;
        wr_status && wr_ones[DSF_ST_INIT] |=> init_skip_wait ##1 !init_skip_wait || $past(wr_status, 1);
    endproperty
    a_init_skip: assert property (p_init_skip) else $error("init skip pulse wrong");

    property p_summary_clear;
        wr_summary && !autoclear && (wr_ones[15:6] == 10'h3FF) |=> summary_val == $past(
            {fault_raw[0] != 0, fault_raw[1] != 0, fault_raw[2] != 0, fault_raw[3] != 0,
             fault_raw[4] != 0, fault_raw[5] != 0, fault_raw[6] != 0, fault_raw[7] != 0,
             fault_raw[8] != 0, fault_raw[9] != 0, 6'h00});
    endproperty
    a_summary_clear: assert property (p_summary_clear) else $error("summary clear failed");

    property p_autoclear;
        autoclear && (fault_raw[0] == '0) |=> !summary_val[DSF_SUM_MSB];
    endproperty
    a_autoclear: assert property (p_autoclear) else $error("fault did not self clear");

endmodule : dsf_status_regs

`default_nettype wire

// >>> verification/device_status_fault_summary_tb.sv
// Testbench: self-checking bench for the status and fault-summary register block
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin fails++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (g), (e)); end end
module device_status_fault_summary_tb;
    import dsf_pkg::*;
    // ----------------------------------------------------------------
    // Signals
    // ----------------------------------------------------------------
    logic                  clk, reset_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
    logic                  s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [DSF_ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
    logic [DSF_DATA_W-1:0] s_axi_wdata, s_axi_rdata, rdat;
    logic [2:0]            s_axi_awprot, s_axi_arprot;
    logic [3:0]            s_axi_wstrb;
    logic [1:0]            s_axi_bresp, s_axi_rresp, resp;
    logic                  chain_fault_pin, link_clear_event, link_reset_event, sample_collected, sample_auto;
    logic                  sample_read, init_busy, init_skip_wait, fault_out, irq;
    logic [15:0]           fault_raw [DSF_FAULT_TYPES];
    logic [15:0]           row_raw [DSF_FAULT_TYPES];
    logic [15:0]           row_sum [DSF_FAULT_TYPES];
    int                    fails, cmp_count, skip_cnt;
    localparam logic [11:0] adr_st  = {DSF_IDX_STATUS, 2'b00};
    localparam logic [11:0] adr_sum = {DSF_IDX_SUMMARY, 2'b00};
    localparam logic [11:0] adr_cfg = {DSF_IDX_CONFIG, 2'b00};
    localparam logic [11:0] adr_ist = {DSF_IDX_IRQ_STATUS, 2'b00};
    localparam logic [11:0] adr_msk = {DSF_IDX_IRQ_MASK, 2'b00};

    dsf_status_regs i_dut (.clk, .reset_n, .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .chain_fault_pin, .link_clear_event, .link_reset_event, .sample_collected, .sample_auto,
        .sample_read, .init_busy, .init_skip_wait, .fault_raw, .fault_out, .irq);

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    always @(posedge clk) if (init_skip_wait === 1'b1) skip_cnt++;

    // ----------------------------------------------------------------
    // Tasks
    // ----------------------------------------------------------------
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask : tick
    task automatic stop_test;
        $display("Counts: %0d mismatches, %0d comparisons", fails, cmp_count);
        if (fails == 0 && cmp_count > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : stop_test
    task automatic hang;
        fails++;
        $display("CHECK FAILED t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
        stop_test();
    endtask : hang
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        int n;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge clk);
            if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
            if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid === 1'b1) break;
        end
        if (n == 50) hang();
        resp = s_axi_bresp;
        s_axi_bready <= 1'b0;
        @(posedge clk);
    endtask : wr
    task automatic rd(input logic [11:0] a);
        int n;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge clk);
            if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid === 1'b1) break;
        end
        if (n == 50) hang();
        rdat = s_axi_rdata;
        resp = s_axi_rresp;
        s_axi_rready <= 1'b0;
        @(posedge clk);
    endtask : rd
    task automatic pulse_ev(input logic clr, input logic rst, input logic col, input logic rdo);
        link_clear_event <= clr;
        link_reset_event <= rst;
        sample_collected <= col;
        sample_read <= rdo;
        tick(1);
        {link_clear_event, link_reset_event, sample_collected, sample_read} <= 4'h0;
        tick(3);
    endtask : pulse_ev

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, reset_n} = 6'h00;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_awprot, s_axi_arprot} = '0;
        {chain_fault_pin, link_clear_event, link_reset_event, sample_collected, sample_auto} = 5'h00;
        {sample_read, init_busy} = 2'h0;
        s_axi_wstrb = 4'hF;
        fails = 0;
        cmp_count = 0;
        skip_cnt = 0;
        for (int i = 0; i < DSF_FAULT_TYPES; i++) begin
            fault_raw[i] = 16'h0000;
            row_raw[i] = 16'h0001 << i;
            row_sum[i] = 16'h8000 >> i;
        end
        tick(2);
        reset_n <= 1'b1;
        tick(2);
        rd(adr_cfg); `CHK(rdat, 32'h2)
        rd(adr_st); `CHK(rdat, 32'h0)
        rd(12'h0FC); `CHK({resp, rdat}, {DSF_RESP_SLVERR, 32'h0})
        $display("Test reset done");
        for (int i = 0; i < DSF_FAULT_TYPES; i++) begin
            fault_raw[i] <= row_raw[i];
            tick(3);
            rd(adr_st); `CHK(rdat[7], 1'b1)
            rd(adr_sum); `CHK(rdat, {16'h0, row_sum[i]})
            fault_raw[i] <= 16'h0;
            wr(adr_sum, 32'h0);
            rd(adr_sum); `CHK(rdat, {16'h0, row_sum[i]})
            wr(adr_sum, {16'h0, row_sum[i]});
            rd(adr_sum); `CHK(rdat, 32'h0)
            rd(adr_st); `CHK(rdat[7], 1'b0)
        end
        {fault_raw[2], fault_raw[7]} <= 32'h00080001;
        tick(3);
        {fault_raw[2], fault_raw[7]} <= 32'h0;
        wr(adr_sum, 32'hFFC0);
        rd(adr_sum); `CHK(rdat, 32'h0)
        $display("Test summary table done");
        chain_fault_pin <= 1'b1;
        tick(4);
        rd(adr_st); `CHK(rdat, 32'h60)
        `CHK(fault_out, 1'b1)
        chain_fault_pin <= 1'b0;
        tick(4);
        rd(adr_st); `CHK(rdat, 32'h20)
        `CHK(fault_out, 1'b0)
        wr(adr_st, 32'hC3);
        rd(adr_st); `CHK(rdat, 32'h20)
        wr(adr_st, 32'h20);
        rd(adr_st); `CHK(rdat, 32'h0)
        wr(adr_cfg, 32'h0);
        chain_fault_pin <= 1'b1;
        tick(4);
        rd(adr_st); `CHK(rdat, 32'h0)
        `CHK(fault_out, 1'b0)
        chain_fault_pin <= 1'b0;
        tick(4);
        wr(adr_cfg, 32'h2);
        $display("Test chain fault done");
        pulse_ev(1'b1, 1'b1, 1'b0, 1'b0);
        rd(adr_st); `CHK(rdat, 32'h18)
        `CHK(fault_out, 1'b0)
        wr(adr_st, 32'h0);
        rd(adr_st); `CHK(rdat, 32'h18)
        wr(adr_st, 32'h18);
        rd(adr_st); `CHK(rdat, 32'h0)
        sample_auto <= 1'b1;
        pulse_ev(1'b0, 1'b0, 1'b1, 1'b0);
        rd(adr_st); `CHK(rdat, 32'h0)
        sample_auto <= 1'b0;
        pulse_ev(1'b0, 1'b0, 1'b1, 1'b0);
        wr(adr_st, 32'h2);
        rd(adr_st); `CHK(rdat, 32'h2)
        pulse_ev(1'b0, 1'b0, 1'b0, 1'b1);
        rd(adr_st); `CHK(rdat, 32'h0)
        $display("Test events and samples done");
        init_busy <= 1'b1;
        wr(adr_st, 32'h0);
        tick(2);
        rd(adr_st); `CHK({skip_cnt == 1, rdat}, {1'b1, 32'h1})
        wr(adr_st, 32'h1);
        tick(2);
        `CHK(skip_cnt, 2)
        init_busy <= 1'b0;
        tick(2);
        rd(adr_st); `CHK(rdat, 32'h0)
        $display("Test init done");
        wr(adr_cfg, 32'h3);
        fault_raw[3] <= 16'h0100;
        tick(3);
        rd(adr_sum); `CHK(rdat, 32'h1000)
        fault_raw[3] <= 16'h0;
        tick(3);
        rd(adr_sum); `CHK(rdat, 32'h0)
        wr(adr_cfg, 32'h2);
        $display("Test autoclear done");
        wr(adr_ist, 32'h1F);
        `CHK(irq, 1'b0)
        pulse_ev(1'b1, 1'b0, 1'b0, 1'b0);
        `CHK(irq, 1'b1)
        wr(adr_msk, 32'h1F);
        tick(2);
        `CHK(irq, 1'b0)
        wr(adr_msk, 32'h0);
        tick(2);
        `CHK(irq, 1'b1)
        wr(adr_ist, 32'h1F);
        tick(2);
        `CHK({resp, irq}, {DSF_RESP_OKAY, 1'b0})
        wr(12'h0FC, 32'hFF); `CHK(resp, DSF_RESP_SLVERR)
        rd(adr_st); `CHK(rdat, 32'h10)
        reset_n <= 1'b0;
        tick(2);
        reset_n <= 1'b1;
        tick(2);
        rd(adr_st); `CHK(rdat, 32'h0)
        $display("Test interrupt and reset done");
        stop_test();
    end
endmodule : device_status_fault_summary_tb
`undef CHK
`default_nettype wire
